// File: pra_buffer_ram.sv
// Byte-wide buffer RAM with a random access port and a streaming port
`timescale 1ns/1ps
module pra_buffer_ram #(
   parameter int DEPTH = 2048
) (
   input  wire logic                  clk_in,
   input  wire pra_pkg::pra_ram_req_t rand_req_in,
   output logic [7:0]                 rand_rdata_out,
   input  wire pra_pkg::pra_ram_req_t strm_req_in,
   output logic [7:0]                 strm_rdata_out
);
   localparam int AW = $clog2(DEPTH);

   logic [7:0] mem [DEPTH];
   logic [7:0] next_rand_rdata;
   logic [7:0] next_strm_rdata;
   logic [7:0] rand_rdata;
   logic [7:0] strm_rdata;
   logic       rand_hit;
   logic       strm_hit;

   // Addresses past the end alias by dropping high bits
   always_comb begin
      rand_hit        = rand_req_in.en && !rand_req_in.we;
      strm_hit        = strm_req_in.en && !strm_req_in.we;
      next_rand_rdata = rand_hit ? mem[rand_req_in.addr[AW-1:0]] : rand_rdata;
      next_strm_rdata = strm_hit ? mem[strm_req_in.addr[AW-1:0]] : strm_rdata;
   end

   // Random port wins a same-address write collision
   always_ff @(posedge clk_in) begin
      rand_rdata <= next_rand_rdata;
      strm_rdata <= next_strm_rdata;
      if (strm_req_in.en && strm_req_in.we) begin
         mem[strm_req_in.addr[AW-1:0]] <= strm_req_in.wdata;
      end
      if (rand_req_in.en && rand_req_in.we) begin
         mem[rand_req_in.addr[AW-1:0]] <= rand_req_in.wdata;
      end
   end

   assign rand_rdata_out = rand_rdata;
   assign strm_rdata_out = strm_rdata;
endmodule

// File: pra_host_model.sv
// Host processor model driving the buffer register port
`timescale 1ns/1ps
module pra_host_model (
   input  wire logic                   clk_in,
   output pra_pkg::pra_host_req_t      host_req_out,
   input  wire logic [7:0]             host_rdata_in,
   input  wire logic                   host_rvalid_in
);
   initial begin
      host_req_out = '0;
   end

   // Released bus shows inverted bits so a stale value never passes
   task automatic idle();
      host_req_out.rd    = 1'b0;
      host_req_out.wr    = 1'b0;
      host_req_out.addr  = ~host_req_out.addr;
      host_req_out.wdata = ~host_req_out.wdata;
   endtask

   // One byte per strobe, pointer loaded by the caller first
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_in);
      host_req_out.wr    = 1'b1;
      host_req_out.addr  = addr;
      host_req_out.wdata = data;
      @(negedge clk_in);
      idle();
   endtask

   // Write strobe then read strobe in the very next cycle, no idle between
   task automatic write_read(input logic [7:0] waddr, input logic [7:0] wdata,
                             input logic [7:0] raddr, output logic [7:0] data, output logic ok);
      @(negedge clk_in);
      host_req_out.wr    = 1'b1;
      host_req_out.addr  = waddr;
      host_req_out.wdata = wdata;
      @(negedge clk_in);
      host_req_out.wr    = 1'b0;
      host_req_out.rd    = 1'b1;
      host_req_out.addr  = raddr;
      @(negedge clk_in);
      idle();
      ok   = host_rvalid_in;
      data = host_rdata_in;
   endtask

   // Answer stands one cycle, so it is taken right after the strobe cycle
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(negedge clk_in);
      host_req_out.rd   = 1'b1;
      host_req_out.addr = addr;
      @(negedge clk_in);
      idle();
      ok   = host_rvalid_in;
      data = host_rdata_in;
   endtask
endmodule

// File: pra_packet_ram_access.sv
// Random access register port into the transmit and receive buffer RAMs
//
// Overview of operation
// R1: Pointer high register holds upper eight bits of the byte address.
// R2: Pointer low register holds lower eight bits of the byte address.
// R3: Reading transmit data register returns transmit RAM byte at pointer.
// R4: Writing transmit data register stores byte into transmit RAM at pointer.
// R5: Reading receive data register returns receive RAM byte at pointer.
// R6: Writing receive data register stores byte into receive RAM at pointer.
// R7: Random path never touches the streaming interface address or data state.
// R8: Pointer high sits at 0x08, pointer low at 0x09.
// R9: Transmit data register at 0x04, receive data register at 0x02.
// R10: Host moves 8-bit values through a data register after setting pointer.
// R11: Host loads the pointer before any data register access.
// R12: Both RAMs share one address space and one pointer pair.
// R13: Data register accesses leave the pointer unchanged.
`timescale 1ns/1ps
module pra_packet_ram_access #(
   parameter int TX_DEPTH = pra_pkg::PRA_TX_DEPTH,
   parameter int RX_DEPTH = pra_pkg::PRA_RX_DEPTH
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire pra_pkg::pra_host_req_t host_req_in,
   output logic [7:0]                 host_rdata_out,
   output logic                       host_rvalid_out,
   input  wire pra_pkg::pra_ram_req_t tx_strm_req_in,
   output logic [7:0]                 tx_strm_rdata_out,
   input  wire pra_pkg::pra_ram_req_t rx_strm_req_in,
   output logic [7:0]                 rx_strm_rdata_out,
   output logic [15:0]                buffer_pointer_out
);
   typedef enum logic [2:0] {
      PRA_SRC_NONE = 3'b000,
      PRA_SRC_PTRH = 3'b001,
      PRA_SRC_PTRL = 3'b010,
      PRA_SRC_TX   = 3'b011,
      PRA_SRC_RX   = 3'b100
   } pra_src_t;

   logic [7:0]            buffer_pointer_high;
   logic [7:0]            buffer_pointer_low;
   logic [7:0]            next_buffer_pointer_high;
   logic [7:0]            next_buffer_pointer_low;
   pra_src_t              rd_src;
   pra_src_t              next_rd_src;
   logic                  rd_pend;
   logic                  next_rd_pend;
   logic [15:0]           ptr;
   pra_pkg::pra_ram_req_t tx_rand_req;
   pra_pkg::pra_ram_req_t rx_rand_req;
   logic [7:0]            tx_rand_rdata;
   logic [7:0]            rx_rand_rdata;
   logic [7:0]            hold_ptrh;
   logic [7:0]            hold_ptrl;
   logic                  sel_tx;
   logic                  sel_rx;

   assign ptr                = {buffer_pointer_high, buffer_pointer_low}; // see R1 see R2
   assign buffer_pointer_out = ptr;
   assign sel_tx = host_req_in.addr == pra_pkg::PRA_OFS_TX_DATA; // see R9
   assign sel_rx = host_req_in.addr == pra_pkg::PRA_OFS_RX_DATA; // see R9

   // Register decode and pointer update
   always_comb begin
      next_buffer_pointer_high = buffer_pointer_high;
      next_buffer_pointer_low  = buffer_pointer_low;
      next_rd_pend             = host_req_in.rd;
      next_rd_src              = PRA_SRC_NONE;
      if (host_req_in.wr) begin
         if (host_req_in.addr == pra_pkg::PRA_OFS_PTR_HIGH) begin // see R8
            next_buffer_pointer_high = host_req_in.wdata; // see R1
         end
         if (host_req_in.addr == pra_pkg::PRA_OFS_PTR_LOW) begin // see R8
            next_buffer_pointer_low = host_req_in.wdata; // see R2
         end
      end
      // Data register accesses fall through: pointer holds, no auto increment
      if (host_req_in.rd) begin // see R13
         case (host_req_in.addr)
            pra_pkg::PRA_OFS_PTR_HIGH: begin
               next_rd_src = PRA_SRC_PTRH;
            end
            pra_pkg::PRA_OFS_PTR_LOW: begin
               next_rd_src = PRA_SRC_PTRL;
            end
            pra_pkg::PRA_OFS_TX_DATA: begin
               next_rd_src = PRA_SRC_TX;
            end
            pra_pkg::PRA_OFS_RX_DATA: begin
               next_rd_src = PRA_SRC_RX;
            end
            default: begin
               next_rd_src = PRA_SRC_NONE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         buffer_pointer_high <= pra_pkg::PRA_RESET_PTR;
         buffer_pointer_low  <= pra_pkg::PRA_RESET_PTR;
         rd_src              <= PRA_SRC_NONE;
         rd_pend             <= 1'b0;
         hold_ptrh           <= pra_pkg::PRA_RESET_PTR;
         hold_ptrl           <= pra_pkg::PRA_RESET_PTR;
      end else begin
         buffer_pointer_high <= next_buffer_pointer_high;
         buffer_pointer_low  <= next_buffer_pointer_low;
         rd_src              <= next_rd_src;
         rd_pend             <= next_rd_pend;
         hold_ptrh           <= buffer_pointer_high;
         hold_ptrl           <= buffer_pointer_low;
      end
   end

   // Same pointer drives both RAMs; streaming ports are separate ports
   always_comb begin
      tx_rand_req.en    = (host_req_in.rd || host_req_in.wr) && sel_tx; // see R3 see R4
      tx_rand_req.we    = host_req_in.wr && sel_tx; // see R4
      tx_rand_req.addr  = ptr; // see R12
      tx_rand_req.wdata = host_req_in.wdata;
      rx_rand_req.en    = (host_req_in.rd || host_req_in.wr) && sel_rx; // see R5 see R6
      rx_rand_req.we    = host_req_in.wr && sel_rx; // see R6
      rx_rand_req.addr  = ptr; // see R12
      rx_rand_req.wdata = host_req_in.wdata;
   end

   // Streaming side has its own port and pointers elsewhere
   pra_buffer_ram #(.DEPTH(TX_DEPTH)) u_tx_ram (
      .clk_in         (clk_in),
      .rand_req_in    (tx_rand_req),
      .rand_rdata_out (tx_rand_rdata),
      .strm_req_in    (tx_strm_req_in), // see R7
      .strm_rdata_out (tx_strm_rdata_out)
   );

   pra_buffer_ram #(.DEPTH(RX_DEPTH)) u_rx_ram (
      .clk_in         (clk_in),
      .rand_req_in    (rx_rand_req),
      .rand_rdata_out (rx_rand_rdata),
      .strm_req_in    (rx_strm_req_in), // see R7
      .strm_rdata_out (rx_strm_rdata_out)
   );

   // Read data one cycle after the strobe; unmapped reads return zero
   always_comb begin
      case (rd_src)
         PRA_SRC_PTRH: begin
            host_rdata_out = hold_ptrh;
         end
         PRA_SRC_PTRL: begin
            host_rdata_out = hold_ptrl;
         end
         PRA_SRC_TX: begin
            host_rdata_out = tx_rand_rdata; // see R3
         end
         PRA_SRC_RX: begin
            host_rdata_out = rx_rand_rdata; // see R5
         end
         default: begin
            host_rdata_out = pra_pkg::PRA_UNMAPPED_READ;
         end
      endcase
   end
   assign host_rvalid_out = rd_pend;

   property p_ptr_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
      (host_req_in.wr && (sel_tx || sel_rx)) |=> $stable(ptr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved on data access"); // see R13

   property p_ptrh_write;
      @(posedge clk_in) disable iff (!rst_n_in)
      (host_req_in.wr && host_req_in.addr == pra_pkg::PRA_OFS_PTR_HIGH)
         |=> (ptr[15:8] == $past(host_req_in.wdata));
   endproperty
   a_ptrh_write: assert property (p_ptrh_write) else $error("pointer high not loaded"); // see R1 see R8

   property p_ptrl_write;
      @(posedge clk_in) disable iff (!rst_n_in)
      (host_req_in.wr && host_req_in.addr == pra_pkg::PRA_OFS_PTR_LOW)
         |=> (ptr[7:0] == $past(host_req_in.wdata));
   endproperty
   a_ptrl_write: assert property (p_ptrl_write) else $error("pointer low not loaded"); // see R2 see R8

   property p_ptrl_readback;
      @(posedge clk_in) disable iff (!rst_n_in)
      (host_req_in.rd && host_req_in.addr == pra_pkg::PRA_OFS_PTR_LOW && !host_req_in.wr)
         |=> (host_rvalid_out && host_rdata_out == $past(ptr[7:0]));
   endproperty
   a_ptrl_readback: assert property (p_ptrl_readback) else $error("pointer low readback wrong"); // see R2

   sequence s_tx_write;
      host_req_in.wr && sel_tx && !host_req_in.rd;
   endsequence
   sequence s_tx_read_same;
      host_req_in.rd && sel_tx && !host_req_in.wr && $stable(ptr);
   endsequence
   property p_tx_roundtrip;
      logic [7:0] d;
      @(posedge clk_in) disable iff (!rst_n_in)
      (s_tx_write, d = host_req_in.wdata) ##1 s_tx_read_same |=> (host_rdata_out == d);
   endproperty
   a_tx_roundtrip: assert property (p_tx_roundtrip) else $error("tx byte not returned"); // see R3 see R4

   sequence s_rx_write;
      host_req_in.wr && sel_rx && !host_req_in.rd;
   endsequence
   sequence s_rx_read_same;
      host_req_in.rd && sel_rx && !host_req_in.wr && $stable(ptr);
   endsequence
   property p_rx_roundtrip;
      logic [7:0] d;
      @(posedge clk_in) disable iff (!rst_n_in)
      (s_rx_write, d = host_req_in.wdata) ##1 s_rx_read_same |=> (host_rdata_out == d);
   endproperty
   a_rx_roundtrip: assert property (p_rx_roundtrip) else $error("rx byte not returned"); // see R5 see R6

   property p_shared_ptr;
      @(posedge clk_in) tx_rand_req.addr == rx_rand_req.addr;
   endproperty
   a_shared_ptr: assert property (p_shared_ptr) else $error("buffers use different pointers"); // see R12

   property p_tx_decode;
      @(posedge clk_in) disable iff (!rst_n_in)
      tx_rand_req.we |-> (host_req_in.addr == pra_pkg::PRA_OFS_TX_DATA && !rx_rand_req.we);
   endproperty
   a_tx_decode: assert property (p_tx_decode) else $error("tx data decode wrong"); // see R9

   property p_stream_isolated;
      @(posedge clk_in) disable iff (!rst_n_in)
      !(host_req_in.rd || host_req_in.wr) |-> !(tx_rand_req.en || rx_rand_req.en);
   endproperty
   a_stream_isolated: assert property (p_stream_isolated) else $error("random port active idle"); // see R7
endmodule

// File: pra_pkg.sv
// Package for the packet buffer random access block
package pra_pkg;
   localparam logic [7:0] PRA_OFS_RX_DATA    = 8'h02;
   localparam logic [7:0] PRA_OFS_TX_DATA    = 8'h04;
   localparam logic [7:0] PRA_OFS_PTR_HIGH   = 8'h08;
   localparam logic [7:0] PRA_OFS_PTR_LOW    = 8'h09;
   localparam logic [7:0] PRA_RESET_PTR      = 8'h00;
   localparam logic [7:0] PRA_RESET_DATA     = 8'h00;
   localparam logic [7:0] PRA_UNMAPPED_READ  = 8'h00;
   localparam int         PRA_ADDR_W         = 16;
   localparam int         PRA_TX_DEPTH       = 2048;
   localparam int         PRA_RX_DEPTH       = 4096;

   // One host bus access, taken in a single cycle
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pra_host_req_t;

   // One byte port of a buffer RAM
   typedef struct packed {
      logic        en;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } pra_ram_req_t;
endpackage

// File: test_packet_ram_random_access.sv
// Self-checking bench for the packet buffer random access port
`timescale 1ns/1ps
module test_packet_ram_random_access;
   logic                   clk_in;
   logic                   rst_n_in;
   pra_pkg::pra_host_req_t host_req;
   pra_pkg::pra_ram_req_t  tx_strm;
   pra_pkg::pra_ram_req_t  rx_strm;
   logic [7:0]             host_rdata;
   logic [7:0]             tx_strm_rdata;
   logic [7:0]             rx_strm_rdata;
   logic                   host_rvalid;
   logic [15:0]            pointer;
   logic [7:0]             rd_val;
   logic                   rd_ok;
   logic [15:0]            addrs [3] = '{16'h0000, 16'h0123, 16'h07FF};
   int                     bad_count = 0;
   int                     n_tests = 0;

   pra_packet_ram_access dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .host_req_in(host_req),
      .host_rdata_out(host_rdata), .host_rvalid_out(host_rvalid),
      .tx_strm_req_in(tx_strm), .tx_strm_rdata_out(tx_strm_rdata),
      .rx_strm_req_in(rx_strm), .rx_strm_rdata_out(rx_strm_rdata),
      .buffer_pointer_out(pointer));
   pra_host_model host (
      .clk_in(clk_in), .host_req_out(host_req),
      .host_rdata_in(host_rdata), .host_rvalid_in(host_rvalid));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd_check(input string what, input logic [7:0] addr, input logic [7:0] exp);
      host.read_reg(addr, rd_val, rd_ok);
      check({what, " valid"}, 16'h0001, {15'h0000, rd_ok});
      check(what, {8'h00, exp}, {8'h00, rd_val});
   endtask

   task automatic wr_rd_check(input string what, input logic [7:0] waddr,
                              input logic [7:0] wdata, input logic [7:0] raddr,
                              input logic [7:0] exp);
      host.write_read(waddr, wdata, raddr, rd_val, rd_ok);
      check({what, " valid"}, 16'h0001, {15'h0000, rd_ok});
      check(what, {8'h00, exp}, {8'h00, rd_val});
   endtask

   task automatic set_ptr(input logic [15:0] p);
      host.write_reg(pra_pkg::PRA_OFS_PTR_HIGH, p[15:8]);
      host.write_reg(pra_pkg::PRA_OFS_PTR_LOW, p[7:0]);
   endtask

   // Streaming port stands in for the packet streaming logic
   task automatic strm_op(input logic is_rx, input logic we, input logic [15:0] a,
                          input logic [7:0] d, output logic [7:0] q);
      pra_pkg::pra_ram_req_t r;
      r = '{en: 1'b1, we: we, addr: a, wdata: d};
      @(negedge clk_in);
      if (is_rx) rx_strm = r; else tx_strm = r;
      @(negedge clk_in);
      r = '{en: 1'b0, we: 1'b0, addr: ~a, wdata: ~d};
      if (is_rx) rx_strm = r; else tx_strm = r;
      q = is_rx ? rx_strm_rdata : tx_strm_rdata;
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      #100000;
      bad_count++;
      print_verdict();
   end

   initial begin
      rst_n_in = 1'b0;
      tx_strm  = '0;
      rx_strm  = '0;
      repeat (5) @(negedge clk_in);
      rst_n_in = 1'b1;
      check("pointer reset", 16'h0000, pointer);
      rd_check("ptr high reset", 8'h08, 8'h00);
      rd_check("ptr low reset", 8'h09, 8'h00);
      rd_check("unmapped read", 8'h03, 8'h00);
      $display("test reset done");
      set_ptr(16'h5AC3);
      check("pointer", 16'h5AC3, pointer);
      rd_check("ptr high", 8'h08, 8'h5A);
      rd_check("ptr low", 8'h09, 8'hC3);
      $display("test pointer done");
      foreach (addrs[i]) begin
         set_ptr(addrs[i]);
         host.write_reg(8'h04, addrs[i][7:0] ^ 8'h3C);
         host.write_reg(8'h02, addrs[i][7:0] ^ 8'hC3);
         rd_check("tx data", 8'h04, addrs[i][7:0] ^ 8'h3C);
         rd_check("rx data", 8'h02, addrs[i][7:0] ^ 8'hC3);
         rd_check("tx again", 8'h04, addrs[i][7:0] ^ 8'h3C);
         check("pointer held", addrs[i], pointer);
      end
      set_ptr(16'h0FFF);
      host.write_reg(8'h02, 8'h9E);
      rd_check("rx top", 8'h02, 8'h9E);
      set_ptr(16'h0723);
      wr_rd_check("tx back to back", 8'h04, 8'hA5, 8'h04, 8'hA5);
      wr_rd_check("rx back to back", 8'h02, 8'h5A, 8'h02, 8'h5A);
      wr_rd_check("high then tx", 8'h08, 8'h01, 8'h04, 8'h1F);
      wr_rd_check("high then rx", 8'h08, 8'h07, 8'h02, 8'h5A);
      wr_rd_check("low then tx", 8'h09, 8'hFF, 8'h04, 8'hC3);
      $display("test data done");
      set_ptr(16'h0200);
      host.write_reg(8'h04, 8'h11);
      strm_op(1'b0, 1'b0, 16'h0200, 8'h00, rd_val);
      check("tx stream read", 16'h0011, {8'h00, rd_val});
      strm_op(1'b1, 1'b1, 16'h0200, 8'h77, rd_val);
      rd_check("rx after stream", 8'h02, 8'h77);
      strm_op(1'b1, 1'b0, 16'h0123, 8'h00, rd_val);
      check("rx stream read", 16'h00E0, {8'h00, rd_val});
      strm_op(1'b0, 1'b1, 16'h0201, 8'h66, rd_val);
      check("pointer stream", 16'h0200, pointer);
      rd_check("tx untouched", 8'h04, 8'h11);
      $display("test stream done");
      host.write_reg(8'h03, 8'hFF);
      host.write_reg(8'h0A, 8'h12);
      check("pointer unmapped", 16'h0200, pointer);
      rd_check("tx unmapped", 8'h04, 8'h11);
      $display("test unmapped done");
      // Buffer contents survive reset, only the pointer returns to zero
      rst_n_in = 1'b0;
      repeat (2) @(negedge clk_in);
      rst_n_in = 1'b1;
      check("pointer after reset", 16'h0000, pointer);
      rd_check("tx after reset", 8'h04, 8'h3C);
      $display("test second reset done");
      print_verdict();
   end
endmodule
